/* File: rdb_map.svh */
/*
 * Constants of the reverse-drive and braking configuration block:
 * register indices, reset values, masks, bus answers and scaling figures.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef RDB_MAP_SVH
`define RDB_MAP_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define RDB_IDX_REV 8'h82
`define RDB_IDX_START 8'h84
`define RDB_IDX_HOFF 8'h86
`define RDB_IDX_STAT 8'h88
`define RDB_ADDR_W 12

// ************************************************************
// Reset values and masks
// ************************************************************
`define RDB_REV_RESET 32'h0000_0000
`define RDB_START_RESET 32'h0000_0000
`define RDB_HOFF_RESET 4'h0
`define RDB_START_WMASK 32'hffff_fff7
`define RDB_HOFF_W 4

// ************************************************************
// Status bit positions
// ************************************************************
`define RDB_ST_OPEN 0
`define RDB_ST_REV_PERR 1
`define RDB_ST_START_PERR 2

// ************************************************************
// Bus answers and scaling
// ************************************************************
`define RDB_RESP_OKAY 2'b00
`define RDB_RESP_SLVERR 2'b10
`define RDB_PERMILLE 10'h3e8
`define RDB_HOFF_LAST 4'ha
`define RDB_CAP_LOW_MA 13'h1f4
`define RDB_CAP_STEP_MA 13'h3e8

`endif

/* File: rdb_pkg.sv */
/*
 * Types of the reverse-drive and braking configuration block.
 * Assumes rdb_map.svh sits in the same folder.
 */
`default_nettype none
`include "rdb_map.svh"

package rdb_pkg;

	// ************************************************************
	// Reverse-drive and braking word, bit 31 down to bit 0
	// ************************************************************
	typedef struct packed {
		logic parity;
		logic [3:0] reverse_first_order_accel_code;
		logic [3:0] reverse_second_order_accel_code;
		logic [2:0] braking_bus_current_cap;
		logic [9:0] braking_proportional_gain;
		logic [9:0] braking_integral_gain;
	} rdb_rev_cfg_t;

	// ************************************************************
	// Decoded physical values
	// ************************************************************
	typedef struct packed {
		logic [16:0] first_accel_dhz;
		logic [16:0] second_accel_dhz;
		logic [12:0] brake_cap_ma;
	} rdb_decoded_t;

endpackage

`default_nettype wire

/* File: rdb_decode.sv */
/*
 * Turns the stored codes into physical values and decides the reverse-drive
 * hand-off to open loop. Purely combinational; the parent registers outputs.
 * Assumes speed and maximum speed share one unit and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rdb_map.svh"

module rdb_decode #(
	parameter int SPEED_W = 16
) (
	input wire rdb_pkg::rdb_rev_cfg_t cfg,
	input wire logic [3:0] reverse_openloop_switch_speed,
	input wire logic [SPEED_W-1:0] motor_speed,
	input wire logic [SPEED_W-1:0] max_speed,
	input wire logic reverse_active,
	output rdb_pkg::rdb_decoded_t decoded,
	output logic open_loop_req
);

	// ************************************************************
	// Lookup functions
	// ************************************************************

	// Acceleration ladder in tenths of Hz/s (or Hz/s2)
	function automatic logic [16:0] accel_dhz(input logic [3:0] code);
		case (code)
			4'h0: accel_dhz = 17'h00001;
			4'h1: accel_dhz = 17'h00005;
			4'h2: accel_dhz = 17'h0000a;
			4'h3: accel_dhz = 17'h00019;
			4'h4: accel_dhz = 17'h00032;
			4'h5: accel_dhz = 17'h00064;
			4'h6: accel_dhz = 17'h000fa;
			4'h7: accel_dhz = 17'h001f4;
			4'h8: accel_dhz = 17'h002ee;
			4'h9: accel_dhz = 17'h003e8;
			4'ha: accel_dhz = 17'h009c4;
			4'hb: accel_dhz = 17'h01388;
			4'hc: accel_dhz = 17'h01d4c;
			4'hd: accel_dhz = 17'h02710;
			4'he: accel_dhz = 17'h0c350;
			default: accel_dhz = 17'h186a0;
		endcase
	endfunction

	// Hand-off threshold in per-mille of maximum speed; codes past 4'ha are unused
	function automatic logic [9:0] handoff_pm(input logic [3:0] code);
		case (code)
			4'h0: handoff_pm = 10'h019;
			4'h1: handoff_pm = 10'h032;
			4'h2: handoff_pm = 10'h04b;
			4'h3: handoff_pm = 10'h064;
			4'h4: handoff_pm = 10'h07d;
			4'h5: handoff_pm = 10'h096;
			4'h6: handoff_pm = 10'h0c8;
			4'h7: handoff_pm = 10'h0fa;
			4'h8: handoff_pm = 10'h12c;
			4'h9: handoff_pm = 10'h190;
			4'ha: handoff_pm = 10'h1f4;
			default: handoff_pm = 10'h000;
		endcase
	endfunction

	// ************************************************************
	// Decoding
	// ************************************************************
	logic [SPEED_W+9:0] speed_scaled;
	logic [SPEED_W+9:0] limit_scaled;

	// Ladders and the braking current cap
	always_comb begin
		decoded.first_accel_dhz = accel_dhz(cfg.reverse_first_order_accel_code); // [R1]
		// Code zero of the second-order ladder means no second-order term
		if (cfg.reverse_second_order_accel_code == 4'h0) begin
			decoded.second_accel_dhz = 17'h00000; // [R2]
		end else begin
			decoded.second_accel_dhz = accel_dhz(cfg.reverse_second_order_accel_code); // [R2]
		end
		if (cfg.braking_bus_current_cap == 3'h0) begin
			decoded.brake_cap_ma = `RDB_CAP_LOW_MA; // [R3]
		end else begin
			decoded.brake_cap_ma = 13'(cfg.braking_bus_current_cap * `RDB_CAP_STEP_MA); // [R3]
		end
	end

	// Cross-multiplied compare avoids a divider: speed*1000 < max*permille
	always_comb begin
		speed_scaled = (SPEED_W+10)'(motor_speed) * (SPEED_W+10)'(`RDB_PERMILLE);
		limit_scaled = (SPEED_W+10)'(max_speed) * (SPEED_W+10)'(handoff_pm(reverse_openloop_switch_speed));
		// Unused codes never hand off, so a bad setting cannot force open loop
		open_loop_req = reverse_active && (reverse_openloop_switch_speed <= `RDB_HOFF_LAST)
			&& (speed_scaled < limit_scaled); // [R8]
	end

endmodule

`default_nettype wire

/* File: rdb_regs.sv */
/*
 * Reverse-drive and active-braking configuration register bank with an
 * AXI4-Lite slave, the motor startup word, the hand-off threshold and status.
 * Assumes one clock, a synchronous active-low reset, and speed inputs on aclk.
 */
// Behaviour
// [R1] Bits 30..27 hold the first-order reverse open-loop acceleration code.
// [R2] Bits 26..23 hold the second-order acceleration code; code zero means none.
// [R3] Bits 22..20 hold the braking bus current cap, 0.5 A then 1 A steps.
// [R4] Bits 19..10 hold the braking proportional gain, value over 128.
// [R5] Bits 9..0 hold the braking integral gain, value over 512.
// [R6] Startup word sits at index 84h and resets to all zero.
// [R7] Reverse-drive word sits at index 82h and resets to all zero.
// [R8] Reverse drive goes open loop below a chosen 2.5..50 percent of maximum speed.
// [R9] Bit 31 is a writable parity bit, reset zero, checked as even parity.
`timescale 1ns/1ps
`default_nettype none
`include "rdb_map.svh"

module rdb_regs #(
	parameter int SPEED_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`RDB_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`RDB_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [SPEED_W-1:0] motor_speed,
	input wire logic [SPEED_W-1:0] max_speed,
	input wire logic reverse_active,
	output rdb_pkg::rdb_rev_cfg_t rev_cfg,
	output logic [31:0] motor_startup_config_one,
	output rdb_pkg::rdb_decoded_t rev_decoded,
	output logic open_loop_mode,
	output logic parity_error
);

	// ************************************************************
	// Helper functions
	// ************************************************************

	// Word-aligned hit on a register index
	function automatic logic idx_hit(input logic [`RDB_ADDR_W-1:0] addr, input logic [7:0] idx);
		idx_hit = (addr[`RDB_ADDR_W-1:2] == {2'b00, idx});
	endfunction

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		lane_merge = res;
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	rdb_pkg::rdb_rev_cfg_t rev_q, rev_d;
	logic [31:0] start_q, start_d;
	logic [`RDB_HOFF_W-1:0] hoff_q, hoff_d;
	logic aw_hold_q, aw_hold_d;
	logic w_hold_q, w_hold_d;
	logic [`RDB_ADDR_W-1:0] waddr_q, waddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	rdb_pkg::rdb_decoded_t dec_c, dec_q;
	logic open_c, open_q;
	logic perr_q, perr_d;
	logic do_write;
	logic wr_hit;
	logic [31:0] status_word;

	// ************************************************************
	// Decoder and hand-off compare
	// ************************************************************
	rdb_decode #(
		.SPEED_W(SPEED_W)
	) u_decode (
		.cfg(rev_q),
		.reverse_openloop_switch_speed(hoff_q),
		.motor_speed(motor_speed),
		.max_speed(max_speed),
		.reverse_active(reverse_active),
		.decoded(dec_c),
		.open_loop_req(open_c)
	);

	// ************************************************************
	// Write channel
	// ************************************************************

	// Address and data are taken in either order; the write lands once both are held
	always_comb begin
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rev_d = rev_q;
		start_d = start_q;
		hoff_d = hoff_q;
		do_write = aw_hold_q && w_hold_q && !bvalid_q;
		wr_hit = idx_hit(waddr_q, `RDB_IDX_REV) || idx_hit(waddr_q, `RDB_IDX_START)
			|| idx_hit(waddr_q, `RDB_IDX_HOFF);
		if (s_axi_awvalid && awready_q) begin
			aw_hold_d = 1'b1;
			waddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_hold_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (do_write) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_hit ? `RDB_RESP_OKAY : `RDB_RESP_SLVERR;
			// Every reverse-drive field, parity included, is plain read/write storage; startup bit 3 is forced to zero
			if (idx_hit(waddr_q, `RDB_IDX_REV)) begin
				rev_d = lane_merge(rev_q, wdata_q, wstrb_q); // [R1] [R2] [R3] [R4] [R5] [R7] [R9]
			end
			if (idx_hit(waddr_q, `RDB_IDX_START)) begin
				start_d = lane_merge(start_q, wdata_q, wstrb_q) & `RDB_START_WMASK; // [R6]
			end
			if (idx_hit(waddr_q, `RDB_IDX_HOFF) && wstrb_q[0]) begin
				hoff_d = wdata_q[`RDB_HOFF_W-1:0]; // [R8]
			end
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// Ready drops while a half is held so a second address cannot overwrite it
		awready_d = !aw_hold_d && !bvalid_d;
		wready_d = !w_hold_d && !bvalid_d;
	end

	// ************************************************************
	// Read channel
	// ************************************************************

	// Status shows live hand-off state and both parity checks
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`RDB_ST_OPEN] = open_q;
		status_word[`RDB_ST_REV_PERR] = ^rev_q;
		status_word[`RDB_ST_START_PERR] = ^start_q;
	end

	// One read at a time; data is captured at the address handshake
	always_comb begin
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (s_axi_arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = `RDB_RESP_OKAY;
			if (idx_hit(s_axi_araddr, `RDB_IDX_REV)) begin
				rdata_d = rev_q; // [R7]
			end else if (idx_hit(s_axi_araddr, `RDB_IDX_START)) begin
				rdata_d = start_q; // [R6]
			end else if (idx_hit(s_axi_araddr, `RDB_IDX_HOFF)) begin
				rdata_d = {28'h0000000, hoff_q};
			end else if (idx_hit(s_axi_araddr, `RDB_IDX_STAT)) begin
				rdata_d = status_word;
			end else begin
				rdata_d = 32'h0000_0000;
				rresp_d = `RDB_RESP_SLVERR;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
		// Address is refused while an answer stands; idle after reset means ready
		arready_d = !rvalid_d;
	end

	// Even parity across each whole word; odd count of ones flags an error
	always_comb begin
		perr_d = (^rev_q) || (^start_q); // [R9]
	end

	// ************************************************************
	// Registers
	// ************************************************************

	// All state clears on reset; configuration words come up zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rev_q <= `RDB_REV_RESET; // [R7]
			start_q <= `RDB_START_RESET; // [R6]
			hoff_q <= `RDB_HOFF_RESET;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `RDB_RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= `RDB_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			dec_q <= '0;
			open_q <= 1'b0;
			perr_q <= 1'b0;
		end else begin
			rev_q <= rev_d;
			start_q <= start_d;
			hoff_q <= hoff_d;
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			dec_q <= dec_c;
			open_q <= open_c; // [R8]
			perr_q <= perr_d;
		end
	end

	// ************************************************************
	// Outputs, all straight from flops
	// ************************************************************
	// Gains leave as raw codes: Kp is a Q3.7 value, Ki a Q1.9 value
	assign rev_cfg = rev_q; // [R4] [R5]
	assign motor_startup_config_one = start_q;
	assign rev_decoded = dec_q;
	assign open_loop_mode = open_q;
	assign parity_error = perr_q;
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

endmodule

`default_nettype wire

/* File: rdb_regs_sva.sv */
/*
 * Checker for the configuration bank: bus answers, reset words, parity, hand-off.
 * Assumes it is bound to rdb_regs and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none

module rdb_regs_sva #(
	parameter int SPEED_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [SPEED_W-1:0] motor_speed,
	input wire logic [SPEED_W-1:0] max_speed,
	input wire logic reverse_active,
	input wire rdb_pkg::rdb_rev_cfg_t rev_cfg,
	input wire logic [31:0] motor_startup_config_one,
	input wire logic open_loop_mode,
	input wire logic parity_error
);
	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Answers stand until taken and come at their fixed distance
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	write_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	// Both words come out of reset cleared
	reset_words_a: assert property (
		$rose(aresetn) |-> rev_cfg == 32'h0000_0000 && motor_startup_config_one == 32'h0000_0000)
		else $error("word not cleared by reset");
	startup_rsvd_a: assert property (motor_startup_config_one[3] == 1'h0)
		else $error("reserved startup bit set");
	// Flag only reports; a word with odd parity is still kept
	parity_flag_a: assert property (
		parity_error == ($past(^rev_cfg) || $past(^motor_startup_config_one)))
		else $error("parity flag wrong");
	// Hand-off needs reverse drive and a speed below maximum
	openloop_gate_a: assert property (
		open_loop_mode |-> $past(reverse_active) && $past(motor_speed) < $past(max_speed))
		else $error("open loop without cause");

	wr_seen_c: cover property (s_axi_bvalid && s_axi_bready);
	rd_seen_c: cover property (s_axi_rvalid && s_axi_rready);
	ol_seen_c: cover property ($rose(open_loop_mode));
endmodule

bind rdb_regs rdb_regs_sva #(.SPEED_W(SPEED_W)) u_sva (.*);

`default_nettype wire

/* File: rdb_regs_test.sv */
/*
 * Self-checking bench for the configuration bank, driven over AXI4-Lite.
 * Assumes the package, the design and its checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rdb_map.svh"

module rdb_regs_test;
	// ************************************************************
	// Signals and design
	// ************************************************************
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [`RDB_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, reverse_active = 1'h0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = '0;
	logic [15:0] motor_speed = '0, max_speed = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, open_loop_mode, parity_error;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, motor_startup_config_one;
	rdb_pkg::rdb_rev_cfg_t rev_cfg;
	rdb_pkg::rdb_decoded_t rev_decoded;
	int err_count = 0, samples_checked = 0;
	// Acceleration ladder in tenths of Hz/s, hand-off points in permille
	int acc_t[16] = '{1, 5, 10, 25, 50, 100, 250, 500, 750, 1000, 2500, 5000, 7500, 10000, 50000, 100000};
	int pm_t[11] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 400, 500};

	rdb_regs #(.SPEED_W(16)) u_dut (.*);

	always #2 aclk = ~aclk;

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge aclk);
	endtask

	// A stuck handshake ends the run instead of hanging it
	task automatic tmo(input int n);
		chk("bus wait", 32'(n >= 40), 32'h0000_0000);
		if (n >= 40) begin
			end_sim();
		end
	endtask

	// Address and data offered together, each released once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		int n;
		logic aw, w;
		n = 0;
		aw = 1'h0;
		w = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw && w) && n < 40) begin
			@(posedge aclk);
			n++;
			aw |= s_axi_awready;
			w |= s_axi_wready;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		while (!s_axi_bvalid && n < 40) begin
			@(posedge aclk);
			n++;
		end
		tmo(n);
		chk("write resp", s_axi_bresp, r);
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 40);
		tmo(n);
		chk("read data", s_axi_rdata, d);
		chk("read resp", s_axi_rresp, r);
		s_axi_rready <= 1'h0;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset;
		@(posedge aclk);
		aresetn <= 1'h0;
		tick(2);
		aresetn <= 1'h1;
		tick(2);
		rd(12'h208, 32'h0000_0000, 2'h0);
		rd(12'h210, 32'h0000_0000, 2'h0);
		rd(12'h218, 32'h0000_0000, 2'h0);
		chk("parity flag", parity_error, 1'h0);
		chk("open loop reset", open_loop_mode, 1'h0);
	endtask

	// Every field gets a distinct value; the word has odd parity
	task automatic t_fields;
		wr(12'h208, 32'h9aea_955a, 4'hf, 2'h0);
		chk("parity bit", rev_cfg.parity, 1'h1);
		chk("accel one code", rev_cfg.reverse_first_order_accel_code, 4'h3);
		chk("accel two code", rev_cfg.reverse_second_order_accel_code, 4'h5);
		chk("cap code", rev_cfg.braking_bus_current_cap, 3'h6);
		chk("kp", rev_cfg.braking_proportional_gain, 10'h2a5);
		chk("ki", rev_cfg.braking_integral_gain, 10'h15a);
		tick(2);
		chk("parity flag", parity_error, 1'h1);
		// Status shows the odd reverse word; startup word is still clear
		rd(12'h220, 32'h0000_0002, 2'h0);
		rd(12'h208, 32'h9aea_955a, 2'h0);
		wr(12'h208, 32'h0000_0000, 4'h1, 2'h0);
		rd(12'h208, 32'h9aea_9500, 2'h0);
	endtask

	task automatic t_ladder;
		for (int i = 0; i < 16; i++) begin
			wr(12'h208, {1'h0, i[3:0], i[3:0], i[2:0], 20'h0_0000}, 4'hf, 2'h0);
			tick(2);
			chk("accel one", rev_decoded.first_accel_dhz, acc_t[i]);
			chk("accel two", rev_decoded.second_accel_dhz, (i == 0) ? 0 : acc_t[i]);
			chk("brake cap", rev_decoded.brake_cap_ma, (i[2:0] == 0) ? 500 : i[2:0] * 1000);
		end
	endtask

	task automatic t_startup;
		wr(12'h210, 32'hffff_ffff, 4'hf, 2'h0);
		rd(12'h210, 32'hffff_fff7, 2'h0);
		chk("startup word", motor_startup_config_one, 32'hffff_fff7);
	endtask

	// Holes in the map and the read-only status refuse writes
	task automatic t_unmapped;
		wr(12'h300, 32'h1234_5678, 4'hf, 2'h2);
		rd(12'h300, 32'h0000_0000, 2'h2);
		wr(12'h220, 32'h0000_0007, 4'hf, 2'h2);
	endtask

	// Codes 0 to 10 are tried one below and at their threshold; unused codes only at zero speed
	task automatic t_handoff;
		max_speed <= 16'h03e8;
		reverse_active <= 1'h1;
		for (int c = 0; c < 16; c++) begin
			wr(12'h218, c, 4'h1, 2'h0);
			rd(12'h218, c, 2'h0);
			for (int k = 0; k < 2; k++) begin
				motor_speed <= (c <= 10) ? pm_t[c] - 1 + k : 0;
				tick(3);
				chk("open loop", open_loop_mode, c <= 10 && k == 0);
				// Both stored words have odd parity here, so bits 1 and 2 stand
				rd(12'h220, 32'h0000_0006 | (c <= 10 && k == 0), 2'h0);
			end
		end
		wr(12'h218, 32'h0000_0000, 4'h1, 2'h0);
		reverse_active <= 1'h0;
		tick(3);
		chk("open loop idle", open_loop_mode, 1'h0);
	endtask

	initial begin
		t_reset();
		t_fields();
		t_ladder();
		t_startup();
		t_unmapped();
		t_handoff();
		t_reset();
		end_sim();
	end
endmodule

`default_nettype wire
